/* rtl/pme_entry_ctrl.sv */
`timescale 1ns/10ps
module pme_entry_ctrl (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire pme_pkg::pme_pins_t pins_in,
    input wire logic portb5_gpio_out_in,
    input wire logic portb5_gpio_oe_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_lvp_wdata_in,
    input wire pme_pkg::pme_erase_req_t erase_req_in,
    output logic low_voltage_prog_enable_out,
    output pme_pkg::pme_mode_t mode_out,
    output logic prog_mode_out,
    output logic portb_bit5_pin_out,
    output logic portb_bit5_pin_oe_out,
    output logic portb_bit5_gpio_in_out,
    output logic erase_block_out,
    output logic erase_row_out,
    output logic erase_reject_out
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pme_pkg::pme_pins_t pins_s1_r;
    pme_pkg::pme_pins_t pins_s2_r;
    logic lvp_r;
    pme_pkg::pme_mode_t mode_r;
    pme_pkg::pme_mode_t mode_nxt;

    function automatic logic pme_is_prog(input pme_pkg::pme_mode_t m);
        return m != pme_pkg::PME_RUN;
    endfunction

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
        end else begin
            pins_s1_r <= pins_in;
            pins_s2_r <= pins_s1_r;
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // High voltage outranks single-supply entry; leaving happens on removal
    always_comb begin
        if (pins_s2_r.master_clear_hv) begin
            mode_nxt = pme_pkg::PME_PROG_HV;
        end else if (lvp_r && pins_s2_r.master_clear_ok && pins_s2_r.prog_entry) begin
            mode_nxt = pme_pkg::PME_PROG_LV;
        end else begin
            mode_nxt = pme_pkg::PME_RUN;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            mode_r <= pme_pkg::PME_RUN;
        end else begin
            case (mode_nxt)
                pme_pkg::PME_PROG_HV: mode_r <= pme_pkg::PME_PROG_HV;
                pme_pkg::PME_PROG_LV: mode_r <= pme_pkg::PME_PROG_LV;
                default: mode_r <= pme_pkg::PME_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration bit
    // ----------------------------------------
    // Reset restores erased default; nonvolatile storage is outside this block
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            lvp_r <= pme_pkg::CFG_LVP_RESET;
        end else if (cfg_wr_in && mode_r == pme_pkg::PME_PROG_HV) begin
            lvp_r <= cfg_lvp_wdata_in;
        end
    end

    // ----------------------------------------
    // Outputs and pin sharing
    // ----------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            low_voltage_prog_enable_out <= pme_pkg::CFG_LVP_RESET;
            mode_out <= pme_pkg::PME_RUN;
            prog_mode_out <= 1'b0;
            portb_bit5_pin_out <= 1'b0;
            portb_bit5_pin_oe_out <= 1'b0;
            portb_bit5_gpio_in_out <= 1'b0;
        end else begin
            low_voltage_prog_enable_out <= lvp_r;
            mode_out <= mode_r;
            prog_mode_out <= pme_is_prog(mode_r);
            if (lvp_r) begin
                portb_bit5_pin_out <= 1'b0;
                portb_bit5_pin_oe_out <= 1'b0;
                portb_bit5_gpio_in_out <= 1'b0;
            end else begin
                portb_bit5_pin_out <= portb5_gpio_out_in;
                portb_bit5_pin_oe_out <= portb5_gpio_oe_in;
                portb_bit5_gpio_in_out <= pins_s2_r.prog_entry;
            end
        end
    end

    // ----------------------------------------
    // Erase arbitration
    // ----------------------------------------
    // One-cycle grants; row erase on protected memory is refused
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            erase_block_out <= 1'b0;
            erase_row_out <= 1'b0;
            erase_reject_out <= 1'b0;
        end else begin
            erase_block_out <= 1'b0;
            erase_row_out <= 1'b0;
            erase_reject_out <= 1'b0;
            if (erase_req_in.valid && pme_is_prog(mode_r)) begin
                case (erase_req_in.kind)
                    pme_pkg::PME_ERASE_BLOCK: erase_block_out <= 1'b1;
                    pme_pkg::PME_ERASE_ROW: begin
                        erase_row_out <= !erase_req_in.protect;
                        erase_reject_out <= erase_req_in.protect;
                    end
                    default: erase_reject_out <= 1'b1;
                endcase
            end
        end
    end

endmodule

/* rtl/pme_pkg.sv */
package pme_pkg;

    // ----------------------------------------
    // Configuration word layout
    // ----------------------------------------
    localparam int CFG4L_LVP_BIT = 2;
    localparam logic CFG_LVP_RESET = 1'b1;
    localparam int PORTB_ENTRY_BIT = 5;

    // ----------------------------------------
    // Mode and erase encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        PME_RUN = 2'b00,
        PME_PROG_LV = 2'b01,
        PME_PROG_HV = 2'b10
    } pme_mode_t;

    typedef enum logic [1:0] {
        PME_ERASE_NONE = 2'b00,
        PME_ERASE_BLOCK = 2'b01,
        PME_ERASE_ROW = 2'b10
    } pme_erase_t;

    typedef struct packed {
        logic master_clear_hv;
        logic master_clear_ok;
        logic prog_entry;
    } pme_pins_t;

    typedef struct packed {
        logic valid;
        pme_erase_t kind;
        logic protect;
    } pme_erase_req_t;

endpackage

/* testbench/pme_chk_sva.sv */
`timescale 1ns/10ps
module pme_chk (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire pme_pkg::pme_pins_t pins_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_lvp_wdata_in,
    input wire pme_pkg::pme_erase_req_t erase_req_in,
    input wire logic low_voltage_prog_enable_out,
    input wire pme_pkg::pme_mode_t mode_out,
    input wire logic prog_mode_out,
    input wire logic portb_bit5_pin_oe_out,
    input wire logic erase_block_out,
    input wire logic erase_row_out,
    input wire logic erase_reject_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire b = low_voltage_prog_enable_out;
    wire h = pins_in.master_clear_hv;
    wire v = erase_req_in.valid;
    sequence s_lv; b && pins_in.prog_entry && pins_in.master_clear_ok && !h; endsequence
    sequence s_idle; !h && !pins_in.prog_entry; endsequence
    // Write is taken against the internal mode, one cycle ahead of mode_out
    sequence s_wr_hv; cfg_wr_in ##1 mode_out == 2'h2; endsequence
    sequence s_wr_no; cfg_wr_in ##1 mode_out != 2'h2; endsequence
    a_pin_reserved: assert property (b && $past(b) |-> !portb_bit5_pin_oe_out)
        else $error("entry pin driven while reserved");
    // Pins reach mode_out four edges after the change, seen at the fifth
    a_hv_entry: assert property (h [*5] |-> mode_out == 2'h2)
        else $error("high voltage entry missed");
    a_lv_entry: assert property (s_lv [*5] |-> mode_out == 2'h1)
        else $error("single supply entry missed");
    a_leave_mode: assert property (s_idle [*5] |-> !prog_mode_out && mode_out == 2'h0)
        else $error("program mode kept");
    a_cfg_ignored: assert property (s_wr_no |=> $stable(b))
        else $error("config bit changed outside hv");
    a_cfg_taken: assert property (s_wr_hv |=> b == $past(cfg_lvp_wdata_in, 2))
        else $error("config write lost");
    a_erase_block: assert property (v && erase_req_in.kind == 2'h1 ##1 prog_mode_out |-> erase_block_out)
        else $error("block erase missing");
    a_row_protect: assert property (v && erase_req_in.kind == 2'h2 && erase_req_in.protect ##1 prog_mode_out
        |-> erase_reject_out)
        else $error("protected row erase not refused");
    a_row_grant: assert property (v && erase_req_in.kind == 2'h2 && !erase_req_in.protect ##1 prog_mode_out
        |-> erase_row_out)
        else $error("row erase missing");
endmodule
bind pme_entry_ctrl pme_chk i_pme_chk (.*);

/* testbench/pme_prog_model.sv */
`timescale 1ns/10ps
module pme_prog_model (
    input wire logic hv_in,
    input wire logic lv_in,
    output pme_pkg::pme_pins_t pins_out
);
    // Entry pin held low unless single-supply entry is wanted
    assign pins_out = '{hv_in, !hv_in, lv_in && !hv_in};
endmodule

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic mclk_in = 0, rstn_in = 0, hv = 0, lv = 0, go = 0, goe = 0, wr = 0, wd = 0;
    logic low_voltage_prog_enable, pm, po, poe, gi, eb, erw, erj;
    pme_pkg::pme_pins_t pins;
    pme_pkg::pme_erase_req_t er = '0;
    pme_pkg::pme_mode_t mode;
    int failures = 0, checks_done = 0, cyc = 0;
    pme_prog_model i_pme_prog_model (.hv_in(hv), .lv_in(lv), .pins_out(pins));
    pme_entry_ctrl i_pme_entry_ctrl (.mclk_in, .rstn_in, .pins_in(pins), .portb5_gpio_out_in(go),
        .portb5_gpio_oe_in(goe), .cfg_wr_in(wr), .cfg_lvp_wdata_in(wd), .erase_req_in(er),
        .low_voltage_prog_enable_out(low_voltage_prog_enable), .mode_out(mode), .prog_mode_out(pm), .portb_bit5_pin_out(po),
        .portb_bit5_pin_oe_out(poe), .portb_bit5_gpio_in_out(gi), .erase_block_out(eb),
        .erase_row_out(erw), .erase_reject_out(erj));
    task summarize;
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(logic [1:0] g, logic [1:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %0d exp %0d", $time, g, e);
        end
    endtask
    task step(int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task t_lv;
        goe = 0;
        lv = 1;
        step(4);
        chk(mode, 2'h1);
        chk({poe, gi}, 2'h0);
        er = '{1'b1, pme_pkg::PME_ERASE_BLOCK, 1'b0};
        step(1);
        chk({eb, erj}, 2'h2);
        er = '{1'b1, pme_pkg::PME_ERASE_ROW, 1'b1};
        step(1);
        chk({erw, erj}, 2'h1);
        er = '{1'b1, pme_pkg::PME_ERASE_ROW, 1'b0};
        step(1);
        chk({erw, erj}, 2'h2);
        er = '0;
        lv = 0;
        step(4);
        chk(mode, 2'h0);
    endtask
    task t_cfg;
        wr = 1;
        step(1);
        wr = 0;
        step(1);
        chk({low_voltage_prog_enable, pm}, 2'h2);
        hv = 1;
        step(4);
        chk(mode, 2'h2);
        wr = 1;
        step(1);
        wr = 0;
        step(1);
        chk({low_voltage_prog_enable, pm}, 2'h1);
        {hv, lv, go, goe} = 4'h7;
        step(4);
        chk(mode, 2'h0);
        chk({poe, po}, 2'h3);
        chk({1'b0, gi}, 2'h1);
    endtask
    initial forever #20 mclk_in = ~mclk_in;
    // Cut a hang short well past the few dozen cycles needed
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            summarize;
        end
    end
    initial begin
        step(8);
        rstn_in = 1;
        step(1);
        chk({low_voltage_prog_enable, poe}, 2'h2);
        t_lv;
        t_cfg;
        summarize;
    end
endmodule
